// file: buck_seq_defs.svh
// Register offsets, field positions and timing counts for the buck start-up sequencer.
`ifndef BUCK_SEQ_DEFS_SVH
`define BUCK_SEQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register map, byte addresses on the AXI4-Lite bus.
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SSLVL 8'h08
`define REG_FLAGS 8'h0C
`define CTRL_SOFT_OFF 0
`define FLAG_OC 0
`define FLAG_HOT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Soft-start level codes, one code per switching cycle of ramp.
// ----------------------------------------------------------------------
`define SS_MAX_CODE 9'h12C
`define PG_SS_CODE 9'h0D2

// ----------------------------------------------------------------------
// Counts in switching cycles; blanking time in nanoseconds, rounded up to clock cycles.
// ----------------------------------------------------------------------
`define HICCUP_CYC 13'h1000
`define PG_DELAY_CYC 9'h100
`define STEP0_LEN 6'h20
`define STEP1_LEN 6'h10
`define STEP2_LEN 6'h08
`define CLK_PERIOD_NS 8
`define BLANK_NS 160
`define BLANK_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: buck_seq_pkg.sv
// Types shared by the sequencer and its register slave.
package buck_seq_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_HICCUP, ST_HOT, ST_HELD} seq_state_e;

  // Whole state of the sequencer.
  typedef struct packed {
    seq_state_e state;
    logic [8:0] ss;
    logic [1:0] step;
    logic [5:0] step_cnt;
    logic first_hs;
    logic [12:0] hic_cnt;
    logic [8:0] pg_cnt;
    logic pg_ok;
    logic oc;
    logic [4:0] blank_cnt;
    logic tracked;
    logic soft_off;
    logic ev_oc;
    logic ev_hot;
  } seq_s;

  // Whole state of the AXI4-Lite slave.
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_s;

endpackage

// file: reg_port_if.sv
// Register access port between the bus slave and the sequencer.
`timescale 1ns/1ps
interface reg_port_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

// file: axil_regs.sv
// AXI4-Lite slave front end that turns bus traffic into register accesses.
`timescale 1ns/1ps
`include "buck_seq_defs.svh"
module axil_regs (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side.
  reg_port_if.bus rif
);

  buck_seq_pkg::axil_s st_r;
  buck_seq_pkg::axil_s st_nxt;

  // Address and data are parked independently so either may come first.
  assign awready = !st_r.aw_got && !st_r.bvalid;
  assign wready = !st_r.w_got && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign rif.wr_en = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rif.wr_addr = st_r.awaddr;
  assign rif.wr_data = st_r.wdata;
  assign rif.wr_strb = st_r.wstrb;
  assign rif.rd_addr = araddr[7:0];

  // Next state of both channels; the write is committed with its response.
  always_comb begin
    st_nxt = st_r;
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end
    if (rif.wr_en) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = rif.wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rif.rd_data;
      st_nxt.rresp = rif.rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // axil_regs

// file: buck_seq.sv
// Start-up, protection and power-good sequencer of a synchronous buck regulator.
// Functional notes
// - Low-side stays off until first high-side pulse.
// - Low-side duty steps 25, 50, 75, 100 percent.
// - Fixed pulse counts per step: 32, 16, 8.
// - Soft-start needs enable, bias and supply valid.
// - Soft-start level ramps linearly to ceiling.
// - Overcurrent watched during the whole ramp.
// - Enable low tristates both gate drivers.
// - Held soft-start stops output; release restarts.
// - Overcurrent when sense below ground, low-side on.
// - Overcurrent latches flag and starts hiccup.
// - Hiccup grounds soft-start for 4096 cycles.
// - Hiccup repeats while the overload persists.
// - Overcurrent sampled 160 ns after low-side rise.
// - Over-temperature turns switches off, discharges soft-start.
// - Restart once temperature falls by hysteresis.
// - Tracking input governs until above threshold.
// - Regulation only inside feedback window.
// - Power-good is open drain, released high.
// - Non-tracking power-good needs soft-start above threshold.
// - Power-good rises 256 cycles after window entry.
// - Lockout on bias or enable keeps gates off.
`timescale 1ns/1ps
`include "buck_seq_defs.svh"
module buck_seq #(
  parameter logic [12:0] HICCUP_CYC = `HICCUP_CYC,
  parameter logic [8:0] PG_DELAY_CYC = `PG_DELAY_CYC,
  parameter logic [8:0] SS_MAX_CODE = `SS_MAX_CODE,
  parameter logic [8:0] PG_SS_CODE = `PG_SS_CODE
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator results.
  input wire logic enable_ok,
  input wire logic bias_ok,
  input wire logic supply_valid,
  input wire logic ss_held,
  input wire logic over_temp,
  input wire logic limit_sense_neg,
  input wire logic fb_in_window,
  input wire logic tracking_mode,
  input wire logic track_above,
  // Switching-cycle timing.
  input wire logic sw_tick,
  input wire logic hs_pulse,
  input wire logic ls_gate,
  // Gate and soft-start control.
  output logic hs_gate_en,
  output logic ls_gate_en,
  output logic gates_hiz,
  output logic [1:0] ls_duty_step,
  output logic [8:0] ss_level,
  output logic ss_discharge,
  output logic ref_internal,
  output logic oc_latched,
  // Open-drain power-good pin.
  input wire logic output_in_window_i,
  output logic output_in_window_o,
  output logic output_in_window_oe,
  // AXI4-Lite slave.
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Pulses issued at each low-side duty step before moving on.
  function automatic logic [5:0] step_len(input logic [1:0] step);
    unique case (step)
      2'h0: step_len = `STEP0_LEN;
      2'h1: step_len = `STEP1_LEN;
      default: step_len = `STEP2_LEN;
    endcase
  endfunction

  // Only the control and flag registers accept writes; status is read only.
  function automatic logic is_mapped(input logic [7:0] addr, input logic wr);
    is_mapped = (addr == `REG_CTRL) || (addr == `REG_FLAGS) ||
                (!wr && ((addr == `REG_STATUS) || (addr == `REG_SSLVL)));
  endfunction

  // Restart into a state with every start-up counter cleared.
  function automatic buck_seq_pkg::seq_s restart(input buck_seq_pkg::seq_s s,
                                                 input buck_seq_pkg::seq_state_e st);
    restart = s;
    restart.state = st;
    restart.ss = '0;
    restart.step = '0;
    restart.step_cnt = '0;
    restart.first_hs = 1'b0;
    restart.hic_cnt = '0;
    restart.pg_cnt = '0;
    restart.pg_ok = 1'b0;
    restart.tracked = 1'b0;
  endfunction

  // ----------------------------------------------------------------------
  // Register front end
  // ----------------------------------------------------------------------

  reg_port_if rif ();

  axil_regs u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  buck_seq_pkg::seq_s st_r;
  buck_seq_pkg::seq_s st_nxt;
  logic por;
  logic blank_done;
  logic in_reg;

  // Power-on ready needs every supply comparator plus software permission.
  assign por = enable_ok && bias_ok && supply_valid && !st_r.soft_off;
  // Switching noise right after the low-side edge is not sampled.
  assign blank_done = (st_r.blank_cnt == 5'(`BLANK_CYC));
  // The output counts as regulated only inside the feedback window.
  assign in_reg = fb_in_window;

  // Register reads and write error decode.
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    rif.rd_err = !is_mapped(rif.rd_addr, 1'b0);
    rif.wr_err = !is_mapped(rif.wr_addr, 1'b1);
    unique case (rif.rd_addr)
      `REG_CTRL: rif.rd_data = {31'h0000_0000, st_r.soft_off};
      `REG_STATUS: rif.rd_data = {22'h00_0000, ref_internal, st_r.first_hs,
                                  st_r.step, output_in_window_i, st_r.pg_ok, st_r.oc, st_r.state};
      `REG_SSLVL: rif.rd_data = {23'h00_0000, st_r.ss};
      `REG_FLAGS: rif.rd_data = {30'h0000_0000, st_r.ev_hot, st_r.ev_oc};
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  // Next state. Software clears are applied first so a same-cycle event wins.
  always_comb begin
    st_nxt = st_r;
    if (!ls_gate) begin
      st_nxt.blank_cnt = '0;
    end else if (!blank_done) begin
      st_nxt.blank_cnt = st_r.blank_cnt + 5'h01;
    end
    if (rif.wr_en && rif.wr_strb[0]) begin
      if (rif.wr_addr == `REG_CTRL) begin
        st_nxt.soft_off = rif.wr_data[`CTRL_SOFT_OFF];
      end
      if (rif.wr_addr == `REG_FLAGS) begin
        st_nxt.ev_oc = st_r.ev_oc && !rif.wr_data[`FLAG_OC];
        st_nxt.ev_hot = st_r.ev_hot && !rif.wr_data[`FLAG_HOT];
      end
    end
    if (!por) begin
      // Lockout or enable removal drops everything back to the off state.
      st_nxt = restart(st_nxt, buck_seq_pkg::ST_OFF);
      st_nxt.oc = 1'b0;
    end else if (over_temp) begin
      // Thermal trip discharges soft-start; comparator hysteresis sets restart.
      st_nxt = restart(st_nxt, buck_seq_pkg::ST_HOT);
      st_nxt.oc = 1'b0;
      st_nxt.ev_hot = 1'b1;
    end else if (ss_held && st_r.state != buck_seq_pkg::ST_HICCUP) begin
      // An outside pull on the soft-start node parks the converter.
      st_nxt = restart(st_nxt, buck_seq_pkg::ST_HELD);
    end else begin
      unique case (st_r.state)
        buck_seq_pkg::ST_OFF, buck_seq_pkg::ST_HOT, buck_seq_pkg::ST_HELD: begin
          // Release of any stop condition starts a fresh soft-start cycle.
          st_nxt = restart(st_nxt, buck_seq_pkg::ST_RUN);
        end
        buck_seq_pkg::ST_RUN: begin
          if (sw_tick && st_r.ss < SS_MAX_CODE) begin
            st_nxt.ss = st_r.ss + 9'h001;
          end
          if (hs_pulse) begin
            st_nxt.first_hs = 1'b1;
          end
          if (sw_tick && st_r.first_hs && st_r.step != 2'h3) begin
            if (st_r.step_cnt == step_len(st_r.step) - 6'h01) begin
              st_nxt.step = st_r.step + 2'h1;
              st_nxt.step_cnt = '0;
            end else begin
              st_nxt.step_cnt = st_r.step_cnt + 6'h01;
            end
          end
          if (tracking_mode && track_above) begin
            st_nxt.tracked = 1'b1;
          end
          // Window dwell counts switching cycles; leaving it restarts the wait.
          if (in_reg && (tracking_mode || st_r.ss >= PG_SS_CODE)) begin
            if (sw_tick && !st_r.pg_ok) begin
              if (st_r.pg_cnt == PG_DELAY_CYC - 9'h001) begin
                st_nxt.pg_ok = 1'b1;
              end else begin
                st_nxt.pg_cnt = st_r.pg_cnt + 9'h001;
              end
            end
          end else begin
            st_nxt.pg_cnt = '0;
            st_nxt.pg_ok = 1'b0;
          end
          // Detection runs for the whole ramp, not only in steady state.
          if (st_r.first_hs && ls_gate && blank_done && limit_sense_neg) begin
            st_nxt = restart(st_nxt, buck_seq_pkg::ST_HICCUP);
            st_nxt.oc = 1'b1;
            st_nxt.ev_oc = 1'b1;
          end
        end
        buck_seq_pkg::ST_HICCUP: begin
          // Soft-start stays grounded while switching cycles are counted.
          if (sw_tick) begin
            if (st_r.hic_cnt == HICCUP_CYC - 13'h0001) begin
              st_nxt = restart(st_nxt, buck_seq_pkg::ST_RUN);
              st_nxt.oc = 1'b0;
            end else begin
              st_nxt.hic_cnt = st_r.hic_cnt + 13'h0001;
            end
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Gates switch only in run; the low side waits for the first high pulse.
  assign hs_gate_en = (st_r.state == buck_seq_pkg::ST_RUN);
  assign ls_gate_en = hs_gate_en && st_r.first_hs;
  assign gates_hiz = (st_r.state == buck_seq_pkg::ST_OFF);
  assign ls_duty_step = st_r.step;
  assign ss_level = st_r.ss;
  assign ss_discharge = (st_r.state != buck_seq_pkg::ST_RUN);
  assign ref_internal = !tracking_mode || st_r.tracked;
  assign oc_latched = st_r.oc;
  // The pin is only ever pulled low; an outside pull-up makes the high.
  assign output_in_window_o = 1'b0;
  assign output_in_window_oe = !st_r.pg_ok;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_HIZ: assert property (
    !enable_ok |=> gates_hiz && !hs_gate_en && !ls_gate_en)
    else $error("Gates not tristated after enable loss.");

  AST_LOCKOUT: assert property (
    !bias_ok |=> !hs_gate_en && !ls_gate_en)
    else $error("Gates active under bias lockout.");

  // A low-side start is legal only straight after a high-side pulse in run.
  AST_PREBIAS: assert property (
    $rose(ls_gate_en) |-> $past(hs_pulse) && hs_gate_en)
    else $error("Low side on before first high pulse.");

  AST_OCTRIP: assert property (
    hs_gate_en && st_r.first_hs && ls_gate && blank_done && limit_sense_neg
      && por && !over_temp && !ss_held
    |=> oc_latched && st_r.state == buck_seq_pkg::ST_HICCUP && ss_level == 9'h000)
    else $error("Overcurrent did not start hiccup.");

  AST_BLANK: assert property (
    $rose(oc_latched) |-> $past(st_r.blank_cnt) == 5'(`BLANK_CYC) && $past(ls_gate))
    else $error("Overcurrent sampled inside blanking time.");

  AST_HICCUP: assert property (
    st_r.state == buck_seq_pkg::ST_HICCUP |-> ss_level == 9'h000 && ss_discharge
      && !hs_gate_en)
    else $error("Soft-start not grounded in hiccup.");

  AST_HICEND: assert property (
    st_r.state == buck_seq_pkg::ST_HICCUP && por && !over_temp && sw_tick
      && st_r.hic_cnt == HICCUP_CYC - 13'h0001
    |=> !oc_latched && hs_gate_en)
    else $error("Hiccup did not restart soft-start.");

  AST_SSCAP: assert property (
    ss_level <= SS_MAX_CODE)
    else $error("Soft-start level above its ceiling.");

  AST_SSRAMP: assert property (
    hs_gate_en && $past(hs_gate_en) |-> ss_level - $past(ss_level) <= 9'h001)
    else $error("Soft-start level not a linear ramp.");

  AST_HOT: assert property (
    over_temp && por |=> !hs_gate_en && ss_discharge && ss_level == 9'h000)
    else $error("Thermal trip left switches on.");

  AST_PGDLY: assert property (
    $rose(st_r.pg_ok) |-> $past(st_r.pg_cnt) == PG_DELAY_CYC - 9'h001
      && $past(fb_in_window))
    else $error("Power-good rose without full window dwell.");

  AST_PGSS: assert property (
    !output_in_window_oe && !$past(tracking_mode) |-> $past(ss_level) >= PG_SS_CODE)
    else $error("Power-good released below soft-start threshold.");

  AST_STEP: assert property (
    hs_gate_en && $past(hs_gate_en) |-> ls_duty_step >= $past(ls_duty_step))
    else $error("Low-side duty step went backwards.");

  COV_HICCUP: cover property (st_r.state == buck_seq_pkg::ST_HICCUP ##1
    st_r.state == buck_seq_pkg::ST_RUN);
  COV_OUTPUT_IN_WINDOW: cover property ($fell(output_in_window_oe));
  COV_FULLDUTY: cover property ($rose(ls_duty_step == 2'h3));
  COV_THERMAL: cover property (st_r.state == buck_seq_pkg::ST_HOT ##1
    st_r.state == buck_seq_pkg::ST_RUN);

endmodule // buck_seq

// file: test_buck_seq.sv
// Self-checking testbench for the buck start-up and fault sequencer.
`timescale 1ns/1ps
`include "buck_seq_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module test_buck_seq;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------------
  localparam logic [8:0] SS_MAX = 9'h00c;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic enable_ok = 1'h0, bias_ok = 1'h0, supply_valid = 1'h0, ss_held = 1'h0;
  logic over_temp = 1'h0, limit_sense_neg = 1'h0, fb_in_window = 1'h0;
  logic tracking_mode = 1'h0, track_above = 1'h0, sw_tick = 1'h0;
  logic hs_pulse = 1'h0, ls_gate = 1'h0;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic hs_gate_en, ls_gate_en, gates_hiz, ss_discharge, ref_internal, oc_latched;
  logic output_in_window_i, output_in_window_o, output_in_window_oe, awready, wready, bvalid, arready, rvalid;
  logic [1:0] ls_duty_step, bresp, rresp;
  logic [8:0] ss_level;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0] rs;
  int miscompares = 0;
  int num_checks = 0;
  int t;

  // Free-running bus clock, 8 ns period.
  always #4 aclk = ~aclk;

  // The power-good wire has an external pull-up, so it reads high when released.
  assign output_in_window_i = output_in_window_oe ? 1'h0 : 1'h1;

  // Short counts keep the hiccup and power-good waits within a quick run.
  buck_seq #(.HICCUP_CYC(13'h0008), .PG_DELAY_CYC(9'h004), .SS_MAX_CODE(SS_MAX),
    .PG_SS_CODE(9'h008)) buck_seq_inst (
    .aclk, .aresetn, .enable_ok, .bias_ok, .supply_valid, .ss_held, .over_temp,
    .limit_sense_neg, .fb_in_window, .tracking_mode, .track_above, .sw_tick,
    .hs_pulse, .ls_gate, .hs_gate_en, .ls_gate_en, .gates_hiz, .ls_duty_step,
    .ss_level, .ss_discharge, .ref_internal, .oc_latched, .output_in_window_i, .output_in_window_o,
    .output_in_window_oe, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);

  // ----------------------------------------------------------------------
  // Expectation functions and closing report.
  // ----------------------------------------------------------------------
  function automatic logic [8:0] exp_ss(input int n);
    return (n > SS_MAX) ? SS_MAX : 9'(n);
  endfunction

  function automatic logic [1:0] exp_step(input int n);
    return (n < 32) ? 2'h0 : (n < 48) ? 2'h1 : (n < 56) ? 2'h2 : 2'h3;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timeout_fail();
    miscompares++;
    tally_and_finish();
  endtask

  // ----------------------------------------------------------------------
  // Drivers; every task returns at a falling edge so outputs have settled.
  // ----------------------------------------------------------------------
  task automatic wait_clk(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Ticks come with a random idle gap, since the design must count ticks, not clocks.
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge aclk) sw_tick <= 1'h1;
      @(posedge aclk) sw_tick <= 1'h0;
      repeat ($urandom_range(2, 0)) @(posedge aclk);
    end
    @(negedge aclk);
  endtask

  task automatic pulse_hs();
    @(posedge aclk) hs_pulse <= 1'h1;
    @(posedge aclk) hs_pulse <= 1'h0;
    wait_clk(2);
  endtask

  // Handshakes are decided at the falling edge, where ready is already stable.
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    bit pa, pw, pb, ta, tw, tb;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    pa = 1;
    pw = 1;
    pb = 1;
    for (k = 0; k < 50 && pb; k++) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      tb = bvalid;
      if (tb) rs = bresp;
      @(posedge aclk);
      pa = pa && !ta;
      awvalid <= pa;
      pw = pw && !tw;
      wvalid <= pw;
      pb = pb && !tb;
      bready <= pb;
    end
    if (pb) timeout_fail();
    @(negedge aclk);
  endtask

  task automatic axi_read(input logic [31:0] a);
    bit pa, pr, ta, tr;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    pa = 1;
    pr = 1;
    for (k = 0; k < 50 && pr; k++) begin
      @(negedge aclk);
      ta = pa && arready;
      tr = rvalid;
      if (tr) rd = rdata;
      if (tr) rs = rresp;
      @(posedge aclk);
      pa = pa && !ta;
      arvalid <= pa;
      pr = pr && !tr;
      rready <= pr;
    end
    if (pr) timeout_fail();
    @(negedge aclk);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(83));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    wait_clk(1);
    `CHK("gates_hiz", 1'h1, gates_hiz)
    `CHK("ss_level", 9'h000, ss_level)
    `CHK("output_in_window_oe", 1'h1, output_in_window_oe)
    axi_read(32'h0000_0010);
    `CHK("rresp", `RESP_SLVERR, rs)
    // Supply valid still low: no start.
    @(posedge aclk);
    enable_ok <= 1'h1;
    bias_ok <= 1'h1;
    wait_clk(4);
    `CHK("hs_gate_en", 1'h0, hs_gate_en)
    @(posedge aclk) supply_valid <= 1'h1;
    wait_clk(3);
    `CHK("hs_gate_en", 1'h1, hs_gate_en)
    `CHK("ls_gate_en", 1'h0, ls_gate_en)
    pulse_hs();
    `CHK("ls_gate_en", 1'h1, ls_gate_en)
    for (t = 1; t <= 60; t++) begin
      tick(1);
      `CHK("ss_level", exp_ss(t), ss_level)
      `CHK("ls_duty_step", exp_step(t), ls_duty_step)
    end
    // Power-good delay counted from window entry.
    @(posedge aclk) fb_in_window <= 1'h1;
    tick(3);
    `CHK("output_in_window_oe", 1'h1, output_in_window_oe)
    tick(1);
    `CHK("output_in_window_oe", 1'h0, output_in_window_oe)
    `CHK("output_in_window_i", 1'h1, output_in_window_i)
    `CHK("output_in_window_o", 1'h0, output_in_window_o)
    @(posedge aclk) fb_in_window <= 1'h0;
    wait_clk(1);
    `CHK("output_in_window_oe", 1'h1, output_in_window_oe)
    @(posedge aclk) tracking_mode <= 1'h1;
    wait_clk(2);
    `CHK("ref_internal", 1'h0, ref_internal)
    @(posedge aclk) track_above <= 1'h1;
    wait_clk(2);
    `CHK("ref_internal", 1'h1, ref_internal)
    @(posedge aclk) tracking_mode <= 1'h0;
    // Overcurrent needs the full blanking time of low-side drive.
    @(posedge aclk);
    limit_sense_neg <= 1'h1;
    ls_gate <= 1'h1;
    fb_in_window <= 1'h1;
    wait_clk(17);
    `CHK("oc_latched", 1'h0, oc_latched)
    wait_clk(8);
    `CHK("oc_latched", 1'h1, oc_latched)
    tick(7);
    `CHK("oc_latched", 1'h1, oc_latched)
    `CHK("ss_discharge", 1'h1, ss_discharge)
    `CHK("ss_level", 9'h000, ss_level)
    @(posedge aclk) ls_gate <= 1'h0;
    tick(1);
    `CHK("oc_latched", 1'h0, oc_latched)
    pulse_hs();
    @(posedge aclk) ls_gate <= 1'h1;
    wait_clk(25);
    `CHK("oc_latched", 1'h1, oc_latched)
    @(posedge aclk);
    limit_sense_neg <= 1'h0;
    ls_gate <= 1'h0;
    tick(8);
    tick(4);
    `CHK("output_in_window_oe", 1'h1, output_in_window_oe)
    tick(12);
    `CHK("output_in_window_oe", 1'h0, output_in_window_oe)
    axi_read(`REG_FLAGS);
    `CHK("flag_oc", 1'h1, rd[`FLAG_OC])
    axi_write(`REG_FLAGS, 32'h0000_0001);
    axi_read(`REG_FLAGS);
    `CHK("flag_oc", 1'h0, rd[`FLAG_OC])
    // Thermal trip and automatic restart.
    @(posedge aclk) over_temp <= 1'h1;
    wait_clk(3);
    `CHK("hs_gate_en", 1'h0, hs_gate_en)
    `CHK("ls_gate_en", 1'h0, ls_gate_en)
    `CHK("ss_discharge", 1'h1, ss_discharge)
    @(posedge aclk) over_temp <= 1'h0;
    wait_clk(3);
    `CHK("hs_gate_en", 1'h1, hs_gate_en)
    axi_read(`REG_FLAGS);
    `CHK("flag_hot", 1'h1, rd[`FLAG_HOT])
    @(posedge aclk) ss_held <= 1'h1;
    wait_clk(3);
    `CHK("hs_gate_en", 1'h0, hs_gate_en)
    @(posedge aclk) ss_held <= 1'h0;
    wait_clk(3);
    `CHK("hs_gate_en", 1'h1, hs_gate_en)
    `CHK("ss_level", 9'h000, ss_level)
    axi_write(`REG_CTRL, $urandom() | 32'h0000_0001);
    wait_clk(3);
    `CHK("gates_hiz", 1'h1, gates_hiz)
    axi_write(`REG_CTRL, 32'h0000_0000);
    // Advance the duty step so the shutdown clear below has something to undo.
    pulse_hs();
    tick(40);
    `CHK("ls_duty_step", exp_step(40), ls_duty_step)
    axi_read(`REG_SSLVL);
    `CHK("sslvl", {23'h00_0000, exp_ss(40)}, rd)
    @(posedge aclk) enable_ok <= 1'h0;
    wait_clk(3);
    `CHK("gates_hiz", 1'h1, gates_hiz)
    `CHK("ls_duty_step", 2'h0, ls_duty_step)
    `CHK("ss_level", 9'h000, ss_level)
    @(posedge aclk);
    enable_ok <= 1'h1;
    bias_ok <= 1'h0;
    wait_clk(3);
    `CHK("hs_gate_en", 1'h0, hs_gate_en)
    `CHK("ls_gate_en", 1'h0, ls_gate_en)
    tally_and_finish();
  end
endmodule // test_buck_seq
